// >>> design/spp_port.sv
`timescale 1ns/10ps
`default_nettype none

module spp_port
  import spp_pkg::*;
#(
  parameter int         FLASH_WAIT_CYC = FLASH_PAGE_WRITE_DELAY_CYC,
  parameter int         EE_WAIT_CYC    = EEPROM_WRITE_DELAY_CYC,
  parameter int         ERASE_WAIT_CYC = CHIP_ERASE_DELAY_CYC,
  parameter int         FUSE_WAIT_CYC  = FUSE_WRITE_DELAY_CYC,
  // identity values are arbitrary
  parameter logic [7:0] SIG_BYTE0      = 8'h11,
  parameter logic [7:0] SIG_BYTE1      = 8'h22,
  parameter logic [7:0] SIG_BYTE2      = 8'h33,
  parameter logic [7:0] CALIB_VALUE    = 8'h80
)(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic core_ce,
  // serial programming pins
  input  wire logic sck,
  input  wire logic mosi,
  input  wire logic progReset_b,
  output logic      miso,
  output logic      misoOe,
  // status
  output logic      progEnabled,
  output logic      busyPollFlag
);

  logic                            pinSync;
  logic                            togSync;
  logic                            togPrev;
  logic                            byteStrobe;
  logic                            rxTog;
  logic [7:0]                      rxByte;
  logic [1:0]                      byteIdx;
  logic [7:0]                      insn0;
  logic [7:0]                      insn1;
  logic [7:0]                      insn2;
  logic [7:0]                      insn3;
  logic                            exec;
  logic                            accept;
  logic [7:0]                      replyByte;
  spp_state_e                      state;
  logic [FLASH_AW-1:0]             sweepAddr;
  logic [BUSY_CNT_W-1:0]           busyCnt;
  logic [FLASH_AW-PAGE_AW-1:0]     pageAddr;
  logic [7:0]                      extAddr;
  logic [7:0]                      lockBits;
  logic [7:0]                      fuseLow;
  logic [7:0]                      fuseHigh;
  logic [7:0]                      fuseExt;
  logic [15:0]                     flashMem [FLASH_WORDS];
  logic [15:0]                     pageBuf  [PAGE_WORDS];
  logic [7:0]                      eeMem    [EE_BYTES];
  logic [7:0]                      eePage   [EE_PAGE_BYTES];
  logic [EE_PAGE_BYTES-1:0]        eeLoaded;
  logic [PAGE_AW-1:0]              loadIdx;
  logic [EE_AW-1:0]                eeWrAddr;
  logic [EE_AW-1:0]                rdEeAddr;
  logic [FLASH_AW-1:0]             rdFlashAddr;
  logic [FLASH_AW-1:0]             wrFlashAddr;
  logic isEnable, isErase, isLoadLo, isLoadHi, isExt, isPageWr;
  logic isEeWr, isEeLoad, isEePageWr, isFuseWr, isKnown;

  function automatic logic [EE_AW-1:0] eeAddrOf(input logic [7:0] hi, input logic [7:0] lo);
    eeAddrOf = {hi[0], lo};
  endfunction

  function automatic logic [FLASH_AW-1:0] wordAddrOf(input logic [7:0] hi, input logic [7:0] lo);
    wordAddrOf = {hi[FLASH_AW-9:0], lo};
  endfunction

  // ****************************************************************
  // link domain and crossings
  // ****************************************************************
  spp_link u_link (
    .sck         (sck),
    .progReset_b (progReset_b),
    .mosi        (mosi),
    .miso        (miso),
    .misoOe      (misoOe),
    .replyByte   (replyByte),
    .rxByte      (rxByte),
    .rxTog       (rxTog)
  );

  spp_sync #(.RST_VAL(1'b1)) u_pin_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .core_ce  (core_ce),
    .asyncIn  (progReset_b),
    .syncOut  (pinSync)
  );

  spp_sync #(.RST_VAL(1'b0)) u_tog_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .core_ce  (core_ce),
    .asyncIn  (rxTog),
    .syncOut  (togSync)
  );

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      togPrev <= 1'b0;
    else if (core_ce)
      togPrev <= togSync;
  end

  // rxByte stays put for eight link clocks after the toggle, so it is safe to take
  assign byteStrobe = togSync ^ togPrev;

  // ****************************************************************
  // instruction assembly
  // ****************************************************************
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      byteIdx <= '0;
      insn0   <= '0;
      insn1   <= '0;
      insn2   <= '0;
      insn3   <= '0;
      exec    <= 1'b0;
    end
    else if (core_ce)
    begin
      exec <= 1'b0;
      if (pinSync)
        byteIdx <= '0;
      else if (byteStrobe)
      begin
        byteIdx <= byteIdx + 2'h1;
        case (byteIdx)
          2'h0: insn0 <= rxByte;
          2'h1: insn1 <= rxByte;
          2'h2: insn2 <= rxByte;
          default:
          begin
            insn3 <= rxByte;
            exec  <= 1'b1;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // decode
  // ****************************************************************
  assign isEnable   = insn0 == OP_ENABLE_B1 && insn1 == OP_ENABLE_B2
                      && insn2 == 8'h00 && insn3 == 8'h00;
  assign isErase    = insn0 == OP_ENABLE_B1 && insn1 == OP_ERASE_B2
                      && insn2 == 8'h00 && insn3 == 8'h00;
  assign isLoadLo   = insn0 == OP_LOAD_LO && insn1 == 8'h00;
  assign isLoadHi   = insn0 == OP_LOAD_HI && insn1 == 8'h00;
  assign isExt      = insn0 == OP_EXT_ADDR && insn1 == 8'h00 && insn3 == 8'h00;
  assign isPageWr   = insn0 == OP_PAGE_WR && insn3 == 8'h00;
  assign isEeWr     = insn0 == OP_EE_WRITE && insn1[7:2] == 6'h00;
  assign isEeLoad   = insn0 == OP_EE_LOAD && insn1 == 8'h00 && insn2[7:2] == 6'h00;
  assign isEePageWr = insn0 == OP_EE_PAGE_WR && insn1[7:2] == 6'h00
                      && insn2[1:0] == 2'h0 && insn3 == 8'h00;
  assign isFuseWr   = insn0 == OP_ENABLE_B1 && insn2 == 8'h00
                      && (insn1 == SUB_LOCK || insn1 == SUB_FUSE_LO
                          || insn1 == SUB_FUSE_HI || insn1 == SUB_FUSE_EXT);
  assign isKnown    = isErase | isLoadLo | isLoadHi | isExt | isPageWr
                      | isEeWr | isEeLoad | isEePageWr | isFuseWr;
  // writes need enable, reset still low and no operation pending
  assign accept     = exec && progEnabled && !pinSync && !busyPollFlag;
  assign loadIdx    = insn2[PAGE_AW-1:0];
  assign eeWrAddr   = eeAddrOf(insn1, insn2);
  assign rdEeAddr   = eeAddrOf(insn1, rxByte);
  assign rdFlashAddr = wordAddrOf(insn1, rxByte);
  assign wrFlashAddr = wordAddrOf(insn1, insn2);

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      progEnabled <= 1'b0;
    else if (core_ce)
    begin
      if (pinSync)
        progEnabled <= 1'b0;
      else if (exec && isEnable)
        progEnabled <= 1'b1;
    end
  end

  // ****************************************************************
  // reply byte for the fourth byte, ready once byte three is in
  // ****************************************************************
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      replyByte <= '0;
    else if (core_ce && byteStrobe && byteIdx == 2'h2)
    begin
      if (insn0 == OP_POLL)
        replyByte <= {7'h00, busyPollFlag};
      else if (insn0 == OP_READ_LO)
        replyByte <= flashMem[rdFlashAddr][7:0];
      else if (insn0 == OP_READ_HI)
        replyByte <= flashMem[rdFlashAddr][15:8];
      else if (insn0 == OP_EE_READ)
        replyByte <= eeMem[rdEeAddr];
      else if (insn0 == OP_RD_LOCK && insn1 == 8'h00)
        replyByte <= lockBits;
      else if (insn0 == OP_RD_LOCK && insn1 == SUB_HIGH_SEL)
        replyByte <= fuseHigh;
      else if (insn0 == OP_RD_FUSE && insn1 == 8'h00)
        replyByte <= fuseLow;
      else if (insn0 == OP_RD_FUSE && insn1 == SUB_HIGH_SEL)
        replyByte <= fuseExt;
      else if (insn0 == OP_RD_SIG && rxByte[1:0] == 2'h0)
        replyByte <= SIG_BYTE0;
      else if (insn0 == OP_RD_SIG && rxByte[1:0] == 2'h1)
        replyByte <= SIG_BYTE1;
      else if (insn0 == OP_RD_SIG)
        replyByte <= SIG_BYTE2;
      else if (insn0 == OP_RD_CAL)
        replyByte <= CALIB_VALUE;
      else
        replyByte <= rxByte;
    end
  end

  // ****************************************************************
  // self-timed operations
  // ****************************************************************
  assign busyPollFlag = state != ST_IDLE;

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      state     <= ST_IDLE;
      sweepAddr <= '0;
      busyCnt   <= '0;
      pageAddr  <= '0;
    end
    else if (core_ce)
    begin
      if (busyCnt != '0)
        busyCnt <= busyCnt - 1'b1;
      case (state)
        ST_IDLE:
        begin
          sweepAddr <= '0;
          if (accept && isErase)
          begin
            state   <= ST_ERASE;
            busyCnt <= BUSY_CNT_W'(ERASE_WAIT_CYC);
          end
          else if (accept && isPageWr)
          begin
            state    <= ST_PAGE_COPY;
            pageAddr <= wrFlashAddr[FLASH_AW-1:PAGE_AW];
            busyCnt  <= BUSY_CNT_W'(FLASH_WAIT_CYC);
          end
          else if (accept && (isEeWr || isEePageWr))
          begin
            state   <= ST_HOLD;
            busyCnt <= BUSY_CNT_W'(EE_WAIT_CYC);
          end
          else if (accept && isFuseWr)
          begin
            state   <= ST_HOLD;
            busyCnt <= BUSY_CNT_W'(FUSE_WAIT_CYC);
          end
        end
        ST_ERASE:
        begin
          sweepAddr <= sweepAddr + 1'b1;
          if (sweepAddr == FLASH_AW'(FLASH_WORDS - 1))
            state <= ST_HOLD;
        end
        ST_PAGE_COPY:
        begin
          sweepAddr <= sweepAddr + 1'b1;
          if (sweepAddr == FLASH_AW'(PAGE_WORDS - 1))
            state <= ST_HOLD;
        end
        default:
        begin
          if (busyCnt <= BUSY_CNT_W'(1))
            state <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // memories
  // ****************************************************************
  // erase and page copy walk one word per clock so no wide write port is built
  always_ff @(posedge core_clk)
  begin
    if (core_ce && state == ST_ERASE)
      flashMem[sweepAddr] <= ERASED_WORD;
    else if (core_ce && state == ST_PAGE_COPY)
      flashMem[{pageAddr, sweepAddr[PAGE_AW-1:0]}] <= pageBuf[sweepAddr[PAGE_AW-1:0]];
  end

  always_ff @(posedge core_clk)
  begin
    if (core_ce && accept && isLoadLo)
      pageBuf[loadIdx][7:0] <= insn3;
    else if (core_ce && accept && isLoadHi)
      pageBuf[loadIdx][15:8] <= insn3;
  end

  always_ff @(posedge core_clk)
  begin
    if (core_ce && state == ST_ERASE && sweepAddr < FLASH_AW'(EE_BYTES))
      eeMem[sweepAddr[EE_AW-1:0]] <= ERASED_BYTE;
    else if (core_ce && accept && isEeWr)
      eeMem[eeWrAddr] <= insn3;
    else if (core_ce && accept && isEePageWr)
    begin
      for (int i = 0; i < EE_PAGE_BYTES; i++)
      begin
        if (eeLoaded[i])
          eeMem[{eeWrAddr[EE_AW-1:EE_PAGE_AW], EE_PAGE_AW'(i)}] <= eePage[i];
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      eeLoaded <= '0;
    else if (core_ce && accept && isEePageWr)
      eeLoaded <= '0;
    else if (core_ce && accept && isEeLoad)
    begin
      eeLoaded[insn2[EE_PAGE_AW-1:0]] <= 1'b1;
      eePage[insn2[EE_PAGE_AW-1:0]]   <= insn3;
    end
  end

  // fuse values are stored as given: zero programs a bit, one leaves it unprogrammed
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      lockBits <= UNPROG_BYTE;
      fuseLow  <= UNPROG_BYTE;
      fuseHigh <= UNPROG_BYTE;
      fuseExt  <= UNPROG_BYTE;
      extAddr  <= '0;
    end
    else if (core_ce)
    begin
      if (accept && isErase)
        lockBits <= UNPROG_BYTE;
      else if (accept && isFuseWr && insn1 == SUB_LOCK)
        lockBits <= insn3;
      if (accept && isFuseWr && insn1 == SUB_FUSE_LO)
        fuseLow <= insn3;
      if (accept && isFuseWr && insn1 == SUB_FUSE_HI)
        fuseHigh <= insn3;
      if (accept && isFuseWr && insn1 == SUB_FUSE_EXT)
        fuseExt <= insn3;
      if (accept && isExt)
        extAddr <= insn2;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b || !core_ce);

  sequence s_erase_go;
    exec && accept && isErase;
  endsequence

  sequence s_reply_slot;
    byteStrobe && byteIdx == 2'h2;
  endsequence

  property p_needs_enable;
    exec && !progEnabled && !isEnable && state == ST_IDLE |=> state == ST_IDLE && !progEnabled;
  endproperty
  a_needs_enable: assert property (p_needs_enable) else $error("write acted without enable");

  property p_reset_exit;
    pinSync |=> !progEnabled && byteIdx == 2'h0;
  endproperty
  a_reset_exit: assert property (p_reset_exit) else $error("enable kept after reset release");

  property p_erase_busy;
    s_erase_go |=> busyPollFlag [*8];
  endproperty
  a_erase_busy: assert property (p_erase_busy) else $error("erase did not hold busy");

  property p_erase_fill;
    state == ST_ERASE |=> flashMem[$past(sweepAddr)] == ERASED_WORD;
  endproperty
  a_erase_fill: assert property (p_erase_fill) else $error("erased word not 0xffff");

  property p_page_low;
    exec && accept && isLoadLo |=> pageBuf[$past(loadIdx)][7:0] == $past(insn3);
  endproperty
  a_page_low: assert property (p_page_low) else $error("page buffer low byte not loaded");

  property p_ee_byte;
    exec && accept && isEeWr |=> eeMem[$past(eeWrAddr)] == $past(insn3);
  endproperty
  a_ee_byte: assert property (p_ee_byte) else $error("eeprom byte not written");

  property p_poll_reply;
    s_reply_slot ##0 insn0 == OP_POLL |=> replyByte == {7'h00, $past(busyPollFlag)};
  endproperty
  a_poll_reply: assert property (p_poll_reply) else $error("poll reply does not show busy");

  property p_ee_read;
    s_reply_slot ##0 insn0 == OP_EE_READ |=> replyByte == eeMem[$past(rdEeAddr)];
  endproperty
  a_ee_read: assert property (p_ee_read) else $error("eeprom read reply wrong");

  property p_junk_ignored;
    exec && !isKnown && state == ST_IDLE |=> state == ST_IDLE;
  endproperty
  a_junk_ignored: assert property (p_junk_ignored) else $error("unknown instruction started work");

  property p_ext_addr;
    exec && accept && isExt |=> extAddr == $past(insn2);
  endproperty
  a_ext_addr: assert property (p_ext_addr) else $error("extended address byte not stored");

endmodule

`default_nettype wire

// >>> common/spp_pkg.sv
package spp_pkg;

  // ****************************************************************
  // core clock and wait delays
  // ****************************************************************
  localparam int CLK_PERIOD_NS              = 100;
  localparam int FLASH_PAGE_WRITE_DELAY_NS  = 2_600_000;
  localparam int EEPROM_WRITE_DELAY_NS      = 3_600_000;
  localparam int CHIP_ERASE_DELAY_NS        = 10_500_000;
  localparam int FUSE_WRITE_DELAY_NS        = 4_500_000;
  // busy time of the device: rounded down so it never outlasts the programmer's wait
  localparam int FLASH_PAGE_WRITE_DELAY_CYC = FLASH_PAGE_WRITE_DELAY_NS / CLK_PERIOD_NS;
  localparam int EEPROM_WRITE_DELAY_CYC     = EEPROM_WRITE_DELAY_NS / CLK_PERIOD_NS;
  localparam int CHIP_ERASE_DELAY_CYC       = CHIP_ERASE_DELAY_NS / CLK_PERIOD_NS;
  localparam int FUSE_WRITE_DELAY_CYC       = FUSE_WRITE_DELAY_NS / CLK_PERIOD_NS;
  localparam int BUSY_CNT_W                 = 17;

  // ****************************************************************
  // memory geometry
  // ****************************************************************
  localparam int FLASH_WORDS   = 8192;
  localparam int FLASH_AW      = 13;
  localparam int PAGE_WORDS    = 64;
  localparam int PAGE_AW       = 6;
  localparam int EE_BYTES      = 512;
  localparam int EE_AW         = 9;
  localparam int EE_PAGE_BYTES = 4;
  localparam int EE_PAGE_AW    = 2;
  localparam int BIT_CNT_W     = 5;

  // ****************************************************************
  // instruction encodings
  // ****************************************************************
  localparam logic [7:0] OP_ENABLE_B1  = 8'hac;
  localparam logic [7:0] OP_ENABLE_B2  = 8'h53;
  localparam logic [7:0] OP_ERASE_B2   = 8'h80;
  localparam logic [7:0] OP_POLL       = 8'hf0;
  localparam logic [7:0] OP_EXT_ADDR   = 8'h4d;
  localparam logic [7:0] OP_LOAD_LO    = 8'h40;
  localparam logic [7:0] OP_LOAD_HI    = 8'h48;
  localparam logic [7:0] OP_PAGE_WR    = 8'h4c;
  localparam logic [7:0] OP_READ_LO    = 8'h20;
  localparam logic [7:0] OP_READ_HI    = 8'h28;
  localparam logic [7:0] OP_EE_READ    = 8'ha0;
  localparam logic [7:0] OP_EE_WRITE   = 8'hc0;
  localparam logic [7:0] OP_EE_LOAD    = 8'hc1;
  localparam logic [7:0] OP_EE_PAGE_WR = 8'hc2;
  localparam logic [7:0] OP_RD_FUSE    = 8'h50;
  localparam logic [7:0] OP_RD_LOCK    = 8'h58;
  localparam logic [7:0] OP_RD_SIG     = 8'h30;
  localparam logic [7:0] OP_RD_CAL     = 8'h38;
  localparam logic [7:0] SUB_HIGH_SEL  = 8'h08;
  localparam logic [7:0] SUB_LOCK      = 8'he0;
  localparam logic [7:0] SUB_FUSE_LO   = 8'ha0;
  localparam logic [7:0] SUB_FUSE_HI   = 8'ha8;
  localparam logic [7:0] SUB_FUSE_EXT  = 8'ha4;

  // ****************************************************************
  // values after reset and erase
  // ****************************************************************
  localparam logic [7:0]  ERASED_BYTE  = 8'hff;
  localparam logic [15:0] ERASED_WORD  = 16'hffff;
  localparam logic [7:0]  UNPROG_BYTE  = 8'hff;

  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PAGE_COPY, ST_HOLD} spp_state_e;

endpackage

// >>> design/spp_sync.sv
`timescale 1ns/10ps
`default_nettype none

module spp_sync
  import spp_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
)(
  // clock
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic core_ce,
  // level
  input  wire logic asyncIn,
  output logic      syncOut
);

  logic stage1;

  // stage1 feeds syncOut and nothing else
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      stage1  <= RST_VAL;
      syncOut <= RST_VAL;
    end
    else if (core_ce)
    begin
      stage1  <= asyncIn;
      syncOut <= stage1;
    end
  end

endmodule

`default_nettype wire

// >>> design/spp_link.sv
`timescale 1ns/10ps
`default_nettype none

module spp_link
  import spp_pkg::*;
(
  // serial pins
  input  wire logic       sck,
  input  wire logic       progReset_b,
  input  wire logic       mosi,
  output logic            miso,
  output logic            misoOe,
  // core side
  input  wire logic [7:0] replyByte,
  output logic [7:0]      rxByte,
  output logic            rxTog
);

  logic [BIT_CNT_W-1:0] bitCnt;
  logic [6:0]           shiftIn;
  logic [7:0]           txShift;
  logic [7:0]           loadByte;

  // ****************************************************************
  // receive on rising edge; reset pin high clears the link at once
  // ****************************************************************
  always_ff @(posedge sck or posedge progReset_b)
  begin
    if (progReset_b)
    begin
      bitCnt  <= '0;
      shiftIn <= '0;
      rxByte  <= '0;
      rxTog   <= 1'b0;
    end
    else
    begin
      shiftIn <= {shiftIn[5:0], mosi};
      bitCnt  <= bitCnt + 1'b1;
      if (bitCnt[2:0] == 3'h7)
      begin
        rxByte <= {shiftIn, mosi};
        rxTog  <= ~rxTog;
      end
    end
  end

  // ****************************************************************
  // transmit on falling edge
  // ****************************************************************
  // reply byte is written by the core during the pause before byte four, then held through it
  always_comb
  begin
    if (bitCnt[4:3] == 2'h3)
      loadByte = replyByte;
    else if (bitCnt[4:3] == 2'h0)
      loadByte = 8'h00;
    else
      loadByte = rxByte;
  end

  always_ff @(negedge sck or posedge progReset_b)
  begin
    if (progReset_b)
    begin
      miso    <= 1'b0;
      misoOe  <= 1'b0;
      txShift <= '0;
    end
    else
    begin
      misoOe <= 1'b1;
      if (bitCnt[2:0] == 3'h0)
      begin
        miso    <= loadByte[7];
        txShift <= {loadByte[6:0], 1'b0};
      end
      else
      begin
        miso    <= txShift[7];
        txShift <= {txShift[6:0], 1'b0};
      end
    end
  end

endmodule

`default_nettype wire

// >>> test/spp_prog_model.sv
`timescale 1ns/10ps
`default_nettype none

module spp_prog_model (
  // serial pins
  output logic      sck,
  output logic      mosi,
  output logic      progReset_b,
  input  wire logic miso
);
  initial
  begin
    sck = 1'b0;
    mosi = 1'b0;
    progReset_b = 1'b0;
  end

  // reset pulse opens a fresh session; the power-up wait is shortened to keep the run short
  task automatic open_session();
    sck = 1'b0;
    progReset_b = 1'b1;
    #2000 progReset_b = 1'b0;
    #2000;
  endtask

  // clock rests high in the gaps so reply bit 7 launches only after the pause
  task automatic xfer(input logic [31:0] cmd, output logic [31:0] got);
    for (int i = 31; i >= 0; i--)
    begin
      if (i % 8 == 7)
        #(i == 7 ? 1000 : 500);
      sck = 1'b0;
      mosi = cmd[i];
      #15 sck = 1'b1;
      got[i] = miso;
      #15;
    end
    sck = 1'b0;
    mosi = ~mosi;
    #800;
  endtask
endmodule

`default_nettype wire

// >>> test/tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb;
  import spp_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        core_ce = 1'b0;
  wire logic   sck, mosi, progReset_b, miso, misoOe, progEnabled, busyPollFlag;
  wire logic   misoPin;
  logic [31:0] got;
  int          fails = 0;
  int          checks = 0;

  always #50 core_clk = ~core_clk;

  // identity values are arbitrary
  spp_port #(.FLASH_WAIT_CYC(80), .EE_WAIT_CYC(10), .ERASE_WAIT_CYC(20), .FUSE_WAIT_CYC(10),
    .SIG_BYTE0(8'h5a), .SIG_BYTE1(8'h5b), .SIG_BYTE2(8'h5c), .CALIB_VALUE(8'h6e))
  u_dut (.core_clk(core_clk), .rst_b(rst_b), .core_ce(core_ce), .sck(sck), .mosi(mosi),
    .progReset_b(progReset_b), .miso(miso), .misoOe(misoOe), .progEnabled(progEnabled),
    .busyPollFlag(busyPollFlag));

  // a released pin reads as the inverse so a bit taken while undriven shows up
  assign misoPin = misoOe ? miso : ~miso;

  spp_prog_model u_prog (.sck(sck), .mosi(mosi), .progReset_b(progReset_b), .miso(misoPin));

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic run(input logic [31:0] c);
    u_prog.xfer(c, got);
  endtask

  task automatic rd(input logic [31:0] c, input logic [7:0] e);
    run(c);
    chk(got[7:0], e);
  endtask

  // a hung operation ends the run instead of spinning
  task automatic wait_idle();
    int n;
    n = 0;
    run(32'hf0000000);
    while (got[0] !== 1'b0)
    begin
      n++;
      if (n > 400)
      begin
        fails++;
        tally_and_finish();
      end
      run(32'hf0000000);
    end
  endtask

  task automatic t_enable();
    u_prog.open_session();
    run(32'hac530000);
    chk(got[15:8], 8'h53);
    chk({7'h00, progEnabled}, 8'h01);
    chk({7'h00, misoOe}, 8'h01);
  endtask

  task automatic t_erase();
    run(32'hac800000);
    chk({7'h00, busyPollFlag}, 8'h01);
    wait_idle();
    rd(32'h20000100, 8'hff);
    rd(32'ha0000100, 8'hff);
  endtask

  task automatic t_flash();
    run(32'h40000512);
    run(32'h48000534);
    run(32'h4d000100);
    run(32'h4c008000);
    wait_idle();
    rd(32'h20008500, 8'h12);
    rd(32'h28008500, 8'h34);
  endtask

  task automatic t_eeprom();
    run(32'hc0010377);
    wait_idle();
    rd(32'ha0010300, 8'h77);
    run(32'hc1000155);
    run(32'hc2010400);
    wait_idle();
    rd(32'ha0010500, 8'h55);
    rd(32'ha0010400, 8'hff);
  endtask

  task automatic t_fuse();
    logic [7:0]  wsub [4];
    logic [15:0] rop [4];
    wsub = '{8'he0, 8'ha0, 8'ha8, 8'ha4};
    rop = '{16'h5800, 16'h5000, 16'h5808, 16'h5008};
    for (int k = 0; k < 4; k++)
    begin
      run({8'hac, wsub[k], 8'h00, 6'h30, k[1:0]});
      wait_idle();
      rd({rop[k], 16'h0000}, {6'h30, k[1:0]});
    end
  endtask

  // signature and calibration reads come from the values set at the instance
  task automatic t_ident();
    rd(32'h30000000, 8'h5a);
    rd(32'h30000100, 8'h5b);
    rd(32'h30000200, 8'h5c);
    rd(32'h38000000, 8'h6e);
  endtask

  // writes before enable and unknown opcodes must leave memory alone
  task automatic t_refuse();
    run(32'hc4010399);
    rd(32'ha0010300, 8'h77);
    u_prog.open_session();
    chk({7'h00, progEnabled}, 8'h00);
    chk({7'h00, misoOe}, 8'h00);
    run(32'hc0010399);
    t_enable();
    rd(32'ha0010300, 8'h77);
  endtask

  initial
  begin
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    core_ce <= 1'b1;
    @(posedge core_clk);
    t_enable();
    t_erase();
    t_flash();
    t_eeprom();
    t_fuse();
    t_ident();
    t_refuse();
    tally_and_finish();
  end
endmodule

`default_nettype wire
